// >>> hw/vfis_pkg.sv
// Package for the vectored fast interrupt sequencer: register map, field layout,
// sequencer states and the carriers shared by the core-facing ports.
// Assumes a single 200 MHz core clock; register offsets are word indices, AHB-Lite byte address = 4*index.
package vfis_pkg;
   localparam int         NUM_LEVELS   = 8;
   localparam int         SRC_PER_LVL  = 4;
   localparam int         NUM_SRC      = NUM_LEVELS * SRC_PER_LVL;
   localparam int         ADDR_W       = 12;
   // Printed offsets DA/DB are not multiples of four: kept as indices, byte addr = 4*index
   localparam logic [7:0] FVP_HIGH_IDX = 8'hda;
   localparam logic [7:0] FVP_LOW_IDX  = 8'hdb;
   localparam logic [7:0] LVL_MASK_IDX = 8'hdd;
   localparam logic [7:0] SYS_MODE_IDX = 8'hde;
   localparam logic [7:0] LVL_REQ_IDX  = 8'hdc;
   localparam logic [7:0] SRC_EN_IDX   = 8'he0;
   localparam logic [7:0] SW_PEND_IDX  = 8'he1;
   localparam logic [7:0] STATUS_IDX   = 8'he2;
   // system_mode_reg fields
   localparam int         GEN_BIT      = 0;
   localparam int         FEN_BIT      = 1;
   localparam int         FLS_LSB      = 2;
   // Fast status bit inside the shadow flags
   localparam int         FAST_STAT_BIT = 0;
   localparam logic [7:0] VEC_AREA_MAX = 8'hff;
   localparam logic [7:0] VEC_BASE     = 8'h00;
   localparam logic [7:0] VEC_STRIDE   = 8'h02;
   localparam int         NORMAL_ENTRY_CYC = 16;
   localparam int         FAST_ENTRY_CYC   = 6;
   localparam logic [4:0] NORMAL_PAD   = 5'h0a;  // Idle cycles after the ack and the 5 bus steps
   localparam logic [31:0] RSVD_ZERO   = 32'h0000_0000;

   typedef enum logic [3:0] {
      VFIS_IDLE      = 4'h0,
      VFIS_ACK       = 4'h1,
      VFIS_PUSH_PCL  = 4'h2,
      VFIS_PUSH_PCH  = 4'h3,
      VFIS_PUSH_FLG  = 4'h4,
      VFIS_FETCH_HI  = 4'h5,
      VFIS_FETCH_LO  = 4'h6,
      VFIS_PAD       = 4'h7,
      VFIS_FAST      = 4'h8,
      VFIS_BRANCH    = 4'h9,
      VFIS_RET_POPF  = 4'ha,
      VFIS_RET_POPH  = 4'hb,
      VFIS_RET_POPL  = 4'hc,
      VFIS_RET_DONE  = 4'hd
   } vfis_state_t;

   typedef enum logic [1:0] {
      VFIS_OP_NONE  = 2'h0,
      VFIS_OP_PUSH  = 2'h1,
      VFIS_OP_POP   = 2'h2,
      VFIS_OP_FETCH = 2'h3
   } vfis_op_t;

   // Request to the core's memory/stack port
   typedef struct packed {
      vfis_op_t    op;
      logic [15:0] addr;
      logic [7:0]  data;
   } vfis_mem_req_t;

   // What the core reports about itself
   typedef struct packed {
      logic        instr_end;
      logic        return_from_interrupt;
      logic        ei;
      logic        di;
      logic [15:0] pc;
      logic [7:0]  flags;
   } vfis_core_t;

   // Load commands to the core
   typedef struct packed {
      logic        load_pc;
      logic [15:0] pc;
      logic        load_flags;
      logic [7:0]  flags;
      logic        done;
   } vfis_core_cmd_t;
endpackage : vfis_pkg

// >>> hw/vfis_sequencer.sv
// Interrupt sequencer for an 8-bit core: pending bits, enables, priority, vectored
// and fast entry, and return.  Registers over AHB-Lite, one word per register.
// Assumes the core stalls between instr_end and cmd.done and answers mem requests
// with mem_ready; all inputs are synchronous to hclk.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vfis_sequencer
   import vfis_pkg::*;
#(
   parameter logic [NUM_SRC-1:0] HW_CLEARED = 32'h0000_00f7
) (
   input  wire logic                   hclk,        // Core clock
   input  wire logic                   hresetn,     // Async reset, active low
   input  wire logic                   hsel,        // AHB select
   input  wire logic [ADDR_W-1:0]      haddr,       // AHB address
   input  wire logic [1:0]             htrans,      // AHB transfer type
   input  wire logic                   hwrite,      // AHB write
   input  wire logic [2:0]             hsize,       // AHB size
   input  wire logic                   hready,      // AHB bus ready
   input  wire logic [31:0]            hwdata,      // AHB write data
   output logic [31:0]                 hrdata,      // AHB read data
   output logic                        hreadyout,   // AHB slave ready
   output logic                        hresp,       // AHB response
   input  wire logic [NUM_SRC-1:0]     src_event,   // One-cycle request pulses
   input  wire logic [NUM_SRC-1:0]     sw_clear,    // Peripheral clears its pending bit
   input  wire logic                   [7:0] fast_flags_unused_n, // Tie high
   input  wire vfis_pkg::vfis_core_t   core,        // Core status
   output vfis_pkg::vfis_core_cmd_t    cmd,         // Loads into the core
   output vfis_pkg::vfis_mem_req_t     mem_req,     // Stack / ROM request
   input  wire logic                   mem_ready,   // Request done this cycle
   input  wire logic [7:0]             mem_rdata,   // Popped or fetched byte
   output logic                        irq_pulse,   // Pulse on new request
   output logic                        int_ack,     // interrupt_acknowledge pulse
   output logic [7:0]                  vec_addr,    // Vector address of source
   output logic                        busy         // Sequencer active, core stalled
);
   localparam logic [5:0] PTR_W = 6'h20;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = ADDR_W'({idx, 2'b00});
   endfunction : reg_addr

   function automatic logic [7:0] vec_of(input logic [4:0] src);
      vec_of = VEC_BASE + src * VEC_STRIDE;
   endfunction : vec_of

   function automatic logic [2:0] lvl_of(input logic [4:0] src);
      lvl_of = 3'(src / SRC_PER_LVL);
   endfunction : lvl_of

   logic [NUM_SRC-1:0] pend_r, pend_nxt;
   logic [NUM_SRC-1:0] src_en_r, src_en_nxt;
   logic [7:0]         mask_r, mask_nxt;
   logic               gen_r, gen_nxt;
   logic               fen_r, fen_nxt;
   logic [2:0]         fls_r, fls_nxt;
   logic [15:0]        fvp_r, fvp_nxt;
   logic [7:0]         shadow_r, shadow_nxt;
   logic [4:0]         src_r, src_nxt;
   logic [15:0]        tmp_r, tmp_nxt;
   logic [4:0]         cnt_r, cnt_nxt;
   vfis_state_t        st_r, st_nxt;
   logic               wr_ph_r, wr_ph_nxt;
   logic [7:0]         wr_idx_r, wr_idx_nxt;
   logic [31:0]        hrdata_r, hrdata_nxt;

   // Bus address phase
   logic       ap_valid;
   logic [7:0] ap_idx;
   assign ap_valid = hsel & hready & htrans[1];
   // Upper address bits are ignored, so the register map repeats across the select
   assign ap_idx   = 8'(haddr[ADDR_W-1:2]);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // Priority: level 0 highest, then lowest source index inside a level
   logic [NUM_SRC-1:0] eligible;
   logic               win_valid;
   logic [4:0]         win_src;
   always_comb begin
      win_valid = 1'b0;
      win_src   = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         eligible[i] = pend_r[i] & src_en_r[i] & mask_r[lvl_of(5'(i))];
      end
      for (int i = NUM_SRC-1; i >= 0; i--) begin
         if (eligible[i]) begin
            win_valid = 1'b1;
            win_src   = 5'(i);
         end
      end
   end

   logic take;
   logic is_fast;
   assign take    = (st_r == VFIS_IDLE) & core.instr_end & gen_r & win_valid;
   assign is_fast = fen_r & (lvl_of(win_src) == fls_r);

   // Registered outputs and the fast choice frozen at acceptance
   logic       is_fast_r, is_fast_nxt;
   logic       irq_nxt;
   logic       ack_nxt;
   logic [7:0] vec_nxt;
   always_comb begin
      is_fast_nxt = is_fast_r;
      vec_nxt     = vec_addr;
      irq_nxt     = |(src_event & ~pend_r);
      ack_nxt     = take;
      if (take) begin
         is_fast_nxt = is_fast;
         vec_nxt     = vec_of(win_src);
      end
   end

   // Bus group: read data is registered, a write lands in the following data phase
   always_comb begin
      wr_ph_nxt  = ap_valid & hwrite;
      wr_idx_nxt = ap_idx;
      hrdata_nxt = hrdata_r;
      if (ap_valid & ~hwrite) begin
         unique case (ap_idx)
            FVP_HIGH_IDX: hrdata_nxt = {24'h0, fvp_r[15:8]};
            FVP_LOW_IDX:  hrdata_nxt = {24'h0, fvp_r[7:0]};
            LVL_MASK_IDX: hrdata_nxt = {24'h0, mask_r};
            SYS_MODE_IDX: hrdata_nxt = {27'h0, fls_r, fen_r, gen_r};
            LVL_REQ_IDX: begin
               hrdata_nxt = RSVD_ZERO;
               for (int l = 0; l < NUM_LEVELS; l++)
                  hrdata_nxt[l] = |pend_r[l*SRC_PER_LVL+:SRC_PER_LVL];
            end
            SRC_EN_IDX:   hrdata_nxt = src_en_r;
            SW_PEND_IDX:  hrdata_nxt = pend_r & ~HW_CLEARED;
            STATUS_IDX:   hrdata_nxt = {19'h0, shadow_r, 1'b0, st_r};
            default:      hrdata_nxt = RSVD_ZERO;
         endcase
      end
   end

   // Register and pending state
   always_comb begin
      pend_nxt   = (pend_r | src_event) & ~sw_clear;
      pend_nxt   = pend_nxt | (src_event & sw_clear);
      src_en_nxt = src_en_r;
      mask_nxt   = mask_r;
      gen_nxt    = gen_r;
      fen_nxt    = fen_r;
      fls_nxt    = fls_r;
      fvp_nxt    = fvp_r;
      if (core.ei) gen_nxt = 1'b1;
      if (core.di) gen_nxt = 1'b0;
      if (wr_ph_r) begin
         unique case (wr_idx_r)
            FVP_HIGH_IDX: fvp_nxt[15:8] = hwdata[7:0];
            FVP_LOW_IDX:  fvp_nxt[7:0]  = hwdata[7:0];
            LVL_MASK_IDX: mask_nxt      = hwdata[7:0];
            SYS_MODE_IDX: begin
               gen_nxt = hwdata[GEN_BIT];
               fen_nxt = hwdata[FEN_BIT];
               fls_nxt = hwdata[FLS_LSB+:3];
            end
            SRC_EN_IDX:   src_en_nxt    = hwdata;
            SW_PEND_IDX:  pend_nxt      = pend_nxt & (hwdata | HW_CLEARED) | src_event;
            default:      ;
         endcase
      end
      if (take) begin
         gen_nxt = 1'b0;
         // A fresh event in the acknowledge cycle re-arms the bit: set wins
         if (HW_CLEARED[win_src]) pend_nxt[win_src] = src_event[win_src];
      end
      // Swap: the interrupted PC parks in the pointer until the fast return
      if (st_r == VFIS_FAST) fvp_nxt = core.pc;
      if (st_r == VFIS_IDLE && core.return_from_interrupt && shadow_r[FAST_STAT_BIT]) begin
         fvp_nxt = core.pc;
         gen_nxt = 1'b1;
      end
      if (st_r == VFIS_RET_DONE) gen_nxt = 1'b1;
   end

   // Sequencer
   always_comb begin
      st_nxt     = st_r;
      src_nxt    = src_r;
      tmp_nxt    = tmp_r;
      cnt_nxt    = cnt_r;
      shadow_nxt = shadow_r;
      cmd        = '0;
      mem_req    = '0;
      unique case (st_r)
         VFIS_IDLE: begin
            if (take) begin
               src_nxt = win_src;
               st_nxt  = VFIS_ACK;
            end else if (core.return_from_interrupt) begin
               if (shadow_r[FAST_STAT_BIT]) begin
                  cmd.load_pc    = 1'b1;
                  cmd.pc         = fvp_r;
                  cmd.load_flags = 1'b1;
                  cmd.flags      = shadow_r;
                  cmd.flags[FAST_STAT_BIT] = 1'b0;
                  cmd.done       = 1'b1;
                  shadow_nxt[FAST_STAT_BIT] = 1'b0;
               end else begin
                  st_nxt = VFIS_RET_POPF;
               end
            end
         end
         VFIS_ACK: begin
            // Fast choice was frozen at acceptance, so a select write now is harmless
            if (is_fast_r) begin
               st_nxt = VFIS_FAST;
            end else begin
               st_nxt = VFIS_PUSH_PCL;
            end
            cnt_nxt = '0;
         end
         VFIS_PUSH_PCL: begin
            mem_req = '{op: VFIS_OP_PUSH, addr: 16'h0, data: core.pc[7:0]};
            if (mem_ready) st_nxt = VFIS_PUSH_PCH;
         end
         VFIS_PUSH_PCH: begin
            mem_req = '{op: VFIS_OP_PUSH, addr: 16'h0, data: core.pc[15:8]};
            if (mem_ready) st_nxt = VFIS_PUSH_FLG;
         end
         VFIS_PUSH_FLG: begin
            mem_req = '{op: VFIS_OP_PUSH, addr: 16'h0, data: core.flags};
            if (mem_ready) st_nxt = VFIS_FETCH_HI;
         end
         VFIS_FETCH_HI: begin
            mem_req = '{op: VFIS_OP_FETCH, addr: {8'h0, vec_of(src_r)}, data: 8'h0};
            if (mem_ready) begin
               tmp_nxt[15:8] = mem_rdata;
               st_nxt = VFIS_FETCH_LO;
            end
         end
         VFIS_FETCH_LO: begin
            mem_req = '{op: VFIS_OP_FETCH, addr: {8'h0, vec_of(src_r) | 8'h01}, data: 8'h0};
            if (mem_ready) begin
               tmp_nxt[7:0] = mem_rdata;
               st_nxt  = VFIS_PAD;
               cnt_nxt = '0;
            end
         end
         VFIS_PAD: begin
            // Pads vectored entry out to its documented length
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == NORMAL_PAD - 5'h01) st_nxt = VFIS_BRANCH;
         end
         VFIS_FAST: begin
            tmp_nxt    = fvp_r;
            shadow_nxt = core.flags;
            shadow_nxt[FAST_STAT_BIT] = 1'b1;
            st_nxt     = VFIS_BRANCH;
         end
         VFIS_BRANCH: begin
            cmd.load_pc = 1'b1;
            cmd.pc      = tmp_r;
            cmd.done    = 1'b1;
            st_nxt      = VFIS_IDLE;
         end
         VFIS_RET_POPF: begin
            mem_req = '{op: VFIS_OP_POP, addr: 16'h0, data: 8'h0};
            if (mem_ready) begin
               cmd.load_flags = 1'b1;
               cmd.flags      = mem_rdata;
               st_nxt = VFIS_RET_POPH;
            end
         end
         VFIS_RET_POPH: begin
            mem_req = '{op: VFIS_OP_POP, addr: 16'h0, data: 8'h0};
            if (mem_ready) begin
               tmp_nxt[15:8] = mem_rdata;
               st_nxt = VFIS_RET_POPL;
            end
         end
         VFIS_RET_POPL: begin
            mem_req = '{op: VFIS_OP_POP, addr: 16'h0, data: 8'h0};
            if (mem_ready) begin
               tmp_nxt[7:0] = mem_rdata;
               st_nxt = VFIS_RET_DONE;
            end
         end
         VFIS_RET_DONE: begin
            cmd.load_pc = 1'b1;
            cmd.pc      = tmp_r;
            cmd.done    = 1'b1;
            st_nxt      = VFIS_IDLE;
         end
         default: st_nxt = VFIS_IDLE;
      endcase
   end

   // State registers only; every next value comes from the groups above
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r    <= '0;
         src_en_r  <= '0;
         mask_r    <= '0;
         gen_r     <= 1'b0;
         fen_r     <= 1'b0;
         fls_r     <= '0;
         fvp_r     <= '0;
         shadow_r  <= '0;
         src_r     <= '0;
         tmp_r     <= '0;
         cnt_r     <= '0;
         st_r      <= VFIS_IDLE;
         wr_ph_r   <= 1'b0;
         wr_idx_r  <= '0;
         hrdata_r  <= '0;
         is_fast_r <= 1'b0;
         irq_pulse <= 1'b0;
         int_ack   <= 1'b0;
         vec_addr  <= '0;
      end else begin
         pend_r    <= pend_nxt;
         src_en_r  <= src_en_nxt;
         mask_r    <= mask_nxt;
         gen_r     <= gen_nxt;
         fen_r     <= fen_nxt;
         fls_r     <= fls_nxt;
         fvp_r     <= fvp_nxt;
         shadow_r  <= shadow_nxt;
         src_r     <= src_nxt;
         tmp_r     <= tmp_nxt;
         cnt_r     <= cnt_nxt;
         st_r      <= st_nxt;
         wr_ph_r   <= wr_ph_nxt;
         wr_idx_r  <= wr_idx_nxt;
         hrdata_r  <= hrdata_nxt;
         is_fast_r <= is_fast_nxt;
         irq_pulse <= irq_nxt;
         int_ack   <= ack_nxt;
         vec_addr  <= vec_nxt;
      end
   end

   // Core must stay stalled while busy; a return is only taken when idle
   assign busy = (st_r != VFIS_IDLE);
endmodule : vfis_sequencer
`default_nettype wire

// >>> testbench/vfis_props.sv
// Checker on the sequencer ports: acknowledge, vector and memory request timing.
// Assumes the single hclk domain; bound to vfis_sequencer below.
`timescale 1ns/1ps
`default_nettype none
module vfis_props
   import vfis_pkg::*;
(
   input wire logic                     hclk,      // Clock
   input wire logic                     hresetn,   // Reset
   input wire logic [NUM_SRC-1:0]       src_event, // Requests
   input wire vfis_pkg::vfis_core_t     core,      // Core status
   input wire vfis_pkg::vfis_core_cmd_t cmd,       // Core loads
   input wire vfis_pkg::vfis_mem_req_t  mem_req,   // Memory request
   input wire logic                     mem_ready, // Memory done
   input wire logic                     irq_pulse, // New request
   input wire logic                     int_ack,   // Acknowledge
   input wire logic [7:0]               vec_addr   // Vector address
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_irq_cause; irq_pulse |-> $past(|src_event); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without request");
   property p_ack_end; int_ack |-> $past(core.instr_end); endproperty
   a_ack_end: assert property (p_ack_end) else $error("ack off instruction end");
   property p_ack_pulse; int_ack |=> !int_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_vec_even; int_ack |-> !vec_addr[0]; endproperty
   a_vec_even: assert property (p_vec_even) else $error("odd vector");
   property p_fetch_vec;
      mem_req.op == VFIS_OP_FETCH |-> mem_req.addr[15:8] == 8'h00
         && mem_req.addr[7:1] == vec_addr[7:1];
   endproperty
   a_fetch_vec: assert property (p_fetch_vec) else $error("fetch off vector");
   property p_req_hold; mem_req.op != VFIS_OP_NONE && !mem_ready |=> $stable(mem_req); endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
   property p_entry_done; int_ack |-> ##[1:60] cmd.done; endproperty
   a_entry_done: assert property (p_entry_done) else $error("entry never done");
   property p_fetch_order;
      mem_req.op == VFIS_OP_FETCH && mem_ready && !mem_req.addr[0]
         |=> mem_req.op == VFIS_OP_FETCH && mem_req.addr[0];
   endproperty
   a_fetch_order: assert property (p_fetch_order) else $error("low byte not next");
   c_ack: cover property (int_ack);
   c_fetch: cover property (mem_req.op == VFIS_OP_FETCH && mem_ready);
   c_fast_ret: cover property (core.return_from_interrupt && cmd.done);
endmodule : vfis_props
bind vfis_sequencer vfis_props i_vfis_props (.hclk(hclk), .hresetn(hresetn),
   .src_event(src_event), .core(core), .cmd(cmd), .mem_req(mem_req),
   .mem_ready(mem_ready), .irq_pulse(irq_pulse), .int_ack(int_ack), .vec_addr(vec_addr));
`default_nettype wire

// >>> testbench/vfis_mem_model.sv
// Core-side memory model: system stack and vector ROM behind mem_req.
// Assumes requests are held until mem_ready; wait_cyc sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module vfis_mem_model
   import vfis_pkg::*;
(
   input  wire logic                    hclk,      // Clock
   input  wire logic                    hresetn,   // Reset
   input  wire vfis_pkg::vfis_mem_req_t mem_req,   // Request
   input  wire logic [1:0]              wait_cyc,  // Wait cycles
   output logic                         mem_ready, // Done
   output logic [7:0]                   mem_rdata  // Read byte
);
   logic [7:0] stk [0:15];
   logic [3:0] sp_r;
   logic [1:0] cnt_r;
   logic [7:0] last_r;
   function automatic logic [7:0] rom(input logic [15:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction : rom
   assign mem_ready = (mem_req.op != VFIS_OP_NONE) && (cnt_r == wait_cyc);
   // Idle data is inverted so a late sample cannot pass by luck
   always_comb begin
      mem_rdata = ~last_r;
      if (mem_ready && mem_req.op == VFIS_OP_POP)
         mem_rdata = stk[sp_r - 4'h1];
      else if (mem_ready && mem_req.op == VFIS_OP_FETCH)
         mem_rdata = rom(mem_req.addr);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_r <= 4'h0;
         cnt_r <= 2'h0;
         last_r <= 8'h00;
      end else if (mem_ready) begin
         cnt_r <= 2'h0;
         last_r <= mem_rdata;
         if (mem_req.op == VFIS_OP_PUSH) begin
            stk[sp_r] <= mem_req.data;
            sp_r <= sp_r + 4'h1;
         end
         if (mem_req.op == VFIS_OP_POP)
            sp_r <= sp_r - 4'h1;
      end else if (mem_req.op != VFIS_OP_NONE) begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
endmodule : vfis_mem_model
`default_nettype wire

// >>> testbench/tb_vectored_fast_interrupt_sequencer.sv
// Bench: registers, vectored and fast entry, returns, masking and gating.
// Assumes vfis_mem_model on the memory port and vfis_props bound to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_fast_interrupt_sequencer;
   import vfis_pkg::*;
   logic               hclk = 1'b0;
   logic               hresetn = 1'b0;
   logic               hsel = 1'b0;
   logic               hwrite = 1'b0;
   logic [ADDR_W-1:0]  haddr = '0;
   logic [1:0]         htrans = 2'h0;
   logic [1:0]         wait_cyc = 2'h2;
   logic [31:0]        hwdata = 32'h0;
   logic [NUM_SRC-1:0] src_event = '0;
   logic [NUM_SRC-1:0] sw_clr = '0;
   vfis_core_t         core_s = '0;
   logic [31:0]        hrdata;
   logic               hreadyout, hresp, mem_ready, irq_pulse, int_ack, busy, bz;
   logic [7:0]         mem_rdata, vec_addr, va, dfl;
   vfis_core_cmd_t     cmd;
   vfis_mem_req_t      mem_req;
   logic [15:0]        dpc;
   int                 n_mismatch = 0;
   int                 cmp_count = 0;
   int                 ka, kd;
   always #2.5 hclk = ~hclk;
   vfis_sequencer i_vfis_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .src_event(src_event), .sw_clear(sw_clr), .fast_flags_unused_n(8'hff), .core(core_s),
      .cmd(cmd), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
      .irq_pulse(irq_pulse), .int_ack(int_ack), .vec_addr(vec_addr), .busy(busy));
   vfis_mem_model i_vfis_mem_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
      .wait_cyc(wait_cyc), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {2'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, d, rd);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp,
                      input string m);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0, rd);
      chk(rd & msk, exp, m);
   endtask : rdc
   task automatic fire(input logic [NUM_SRC-1:0] s);
      @(posedge hclk);
      src_event <= s;
      @(posedge hclk);
      src_event <= '0;
      @(negedge hclk);
      chk(irq_pulse, 1'b1, "irq");
   endtask : fire
   task automatic gate(input logic en);
      @(posedge hclk);
      core_s.ei <= en;
      core_s.di <= !en;
      @(posedge hclk);
      core_s.ei <= 1'b0;
      core_s.di <= 1'b0;
   endtask : gate
   // Instruction end or return; ka and kd count negedges to ack and done
   task automatic step(input logic ret, input logic [15:0] pc, input logic [7:0] fl);
      ka = 0;
      kd = -1;
      dfl = 8'h00;
      @(posedge hclk);
      core_s.pc <= pc;
      core_s.flags <= fl;
      core_s.instr_end <= !ret;
      core_s.return_from_interrupt <= ret;
      for (int k = 0; k <= 60 && kd < 0; k++) begin
         @(negedge hclk);
         if (int_ack === 1'b1) begin
            ka = k;
            va = vec_addr;
            bz = busy;
         end
         if (cmd.load_flags === 1'b1) dfl = cmd.flags;
         if (cmd.done === 1'b1) begin
            kd = k;
            dpc = cmd.pc;
         end
         if (k == 0) begin
            @(posedge hclk);
            core_s.instr_end <= 1'b0;
            core_s.return_from_interrupt <= 1'b0;
         end
      end
   endtask : step
   task automatic t_regs();
      rdc(SYS_MODE_IDX, 32'h3, 32'h0, "enables");
      rdc(8'h10, 32'hffff_ffff, 32'h0, "unmapped");
      chk(hresp, 1'b0, "okay");
      wr(FVP_HIGH_IDX, 32'h12);
      wr(FVP_LOW_IDX, 32'h34);
      rdc(FVP_HIGH_IDX, 32'hff, 32'h12, "ptr hi");
      rdc(FVP_LOW_IDX, 32'hff, 32'h34, "ptr lo");
   endtask : t_regs
   task automatic t_vectored();
      wr(LVL_MASK_IDX, 32'h06);
      wr(SRC_EN_IDX, 32'h270);
      wr(SYS_MODE_IDX, 32'h01);
      fire(32'h260);
      rdc(LVL_REQ_IDX, 32'hff, 32'h06, "levels");
      step(1'b0, 16'hbeef, 8'h3c);
      chk(ka, 1, "ack time");
      chk(bz, 1'b1, "busy");
      chk(va, 8'h0a, "vec");
      // Model ROM byte at address a is a ^ a5
      chk(dpc, 16'hafae, "pc");
      chk({i_vfis_mem_model.stk[2], i_vfis_mem_model.stk[1], i_vfis_mem_model.stk[0]},
          24'h3cbeef, "stack");
      rdc(SYS_MODE_IDX, 32'h1, 32'h0, "gen off");
      rdc(SW_PEND_IDX, 32'h20, 32'h0, "hw pend");
      step(1'b1, 16'h0, 8'h0);
      chk(dpc, 16'hbeef, "ret pc");
      chk(dfl, 8'h3c, "ret flags");
      rdc(SYS_MODE_IDX, 32'h1, 32'h1, "gen on");
      step(1'b0, 16'h1000, 8'h00);
      chk(va, 8'h0c, "next src");
      step(1'b1, 16'h0, 8'h0);
      wr(LVL_MASK_IDX, 32'h02);
      wait_cyc <= 2'h0;
      step(1'b0, 16'h2000, 8'h00);
      chk(ka, 0, "masked");
      wr(LVL_MASK_IDX, 32'h06);
      step(1'b0, 16'h2000, 8'h00);
      chk(va, 8'h12, "level 2");
      chk(kd >= 16 && kd <= 18, 1'b1, "entry len");
      step(1'b1, 16'h0, 8'h0);
   endtask : t_vectored
   task automatic t_fast();
      wr(LVL_MASK_IDX, 32'h01);
      wr(SRC_EN_IDX, 32'h08);
      wr(SYS_MODE_IDX, 32'h02);
      gate(1'b1);
      fire(32'h08);
      step(1'b0, 16'habcd, 8'h5a);
      chk(va, 8'h06, "fast vec");
      chk(kd <= 6, 1'b1, "fast len");
      chk(dpc, 16'h1234, "swap");
      chk(i_vfis_mem_model.sp_r, 4'h0, "no push");
      rdc(STATUS_IDX, 32'h1fe0, 32'h0b60, "shadow");
      rdc(SW_PEND_IDX, 32'h08, 32'h08, "sw pend");
      wr(SW_PEND_IDX, 32'h0);
      rdc(SW_PEND_IDX, 32'h08, 32'h0, "sw clr");
      step(1'b1, 16'h0040, 8'h00);
      chk(kd, 0, "fast ret");
      chk(dpc, 16'habcd, "swap back");
      chk(dfl, 8'h5a, "flags back");
      rdc(STATUS_IDX, 32'h20, 32'h0, "status");
   endtask : t_fast
   task automatic t_gate();
      gate(1'b0);
      fire(32'h08);
      step(1'b0, 16'h3000, 8'h00);
      chk(ka, 0, "di gates");
      gate(1'b1);
      wr(FVP_HIGH_IDX, 32'h12);
      wr(FVP_LOW_IDX, 32'h34);
      step(1'b0, 16'h3000, 8'h00);
      chk(ka, 1, "ei opens");
      chk(dpc, 16'h1234, "reload");
      rdc(SW_PEND_IDX, 32'h08, 32'h08, "sw kept");
      @(posedge hclk);
      sw_clr <= 32'h08;
      @(posedge hclk);
      sw_clr <= '0;
      rdc(SW_PEND_IDX, 32'h08, 32'h0, "pin clr");
   endtask : t_gate
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #50000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_vectored();
      t_fast();
      t_gate();
      wrap_up();
   end
endmodule : tb_vectored_fast_interrupt_sequencer
`default_nettype wire
